// file: rtl/crt_pkg.sv
// Package for the carrier receiver trip logic: register map, field layout,
// reset values and timing counts. Assumes a 40 MHz system clock.
package crt_pkg;

  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned MS_CYCLES     = CLK_HZ / 1000;
  localparam int unsigned UNBLOCK_MS    = 150;
  localparam int unsigned UNBLOCK_CYC   = UNBLOCK_MS * MS_CYCLES;
  localparam int unsigned HOLD10_CYC    = 10 * MS_CYCLES;
  localparam int unsigned HOLD50_CYC    = 50 * MS_CYCLES;
  localparam int unsigned HOLD100_CYC   = 100 * MS_CYCLES;
  localparam int unsigned TDLY_STEP_MS  = 2;
  localparam int unsigned TDLY_STEP_CYC = TDLY_STEP_MS * MS_CYCLES;

  // Register byte offsets (classic Wishbone, one word each)
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_IRQ    = 4'h8;
  localparam logic [3:0] REG_MASK   = 4'hc;

  // Control field positions
  localparam int CTRL_VAR_LSB   = 0;   // 2 bits, variant
  localparam int CTRL_CBSEL     = 2;   // checkback frequency select
  localparam int CTRL_TDLY_LSB  = 4;   // 4 bits, trip delay in 2 ms steps
  localparam int CTRL_THOLD_LSB = 8;   // 2 bits
  localparam int CTRL_GHOLD_LSB = 10;  // 2 bits
  localparam int CTRL_UBEN      = 12;  // unblock window enable
  localparam logic [12:0] CTRL_RESET = 13'h0000;

  localparam int NUM_IRQ = 4;
  localparam int IRQ_TRIP = 0;
  localparam int IRQ_CB   = 1;
  localparam int IRQ_LOC  = 2;
  localparam int IRQ_NOIS = 3;

  typedef enum logic [1:0] {
    CRT_VAR_2F_DIR,
    CRT_VAR_3F_DIR,
    CRT_VAR_2F_PHASE
  } crt_variant_e;

  typedef struct packed {
    logic high_f;
    logic center_f;
    logic low_f;
    logic noise;
    logic low_level;
  } crt_disc_s;

  typedef struct packed {
    logic good_chan;
    logic trip;
    logic guard;
    logic checkback;
    logic ubpt_trip;
    logic dtt_trip;
    logic mark;
    logic space;
  } crt_led_s;

  typedef struct packed {
    logic ss_trip2;
    logic ss_guard;
    logic ss_low;
    logic ss_checkback;
    logic ss_noise;
    logic ss_mark;
    logic ss_space;
    logic em_trip;
    logic em_guard;
  } crt_out_s;

endpackage : crt_pkg

// file: rtl/crt_trip_logic.sv
// Receiver decision logic: discriminator flags in, trip/guard/checkback
// outputs and indicators out. Wishbone classic slave for configuration.
// Assumes discriminator flags are level signals, not clock related.
//
// Behaviour
// RULE1 - Take high, center and low frequency flags plus noise and low level flags.
// RULE2 - Good channel lights only while neither noise nor low level is present.
// RULE3 - In two-frequency directional mode trip follows a low-shifted frequency.
// RULE4 - In two-frequency directional mode guard follows the high frequency.
// RULE5 - Low after channel loss with no guard return lights checkback alone.
// RULE6 - In three-frequency mode a switch picks the high or low shift for checkback.
// RULE7 - Selected shift after channel loss without guard lights checkback, no trip.
// RULE8 - In three-frequency mode a high shift gives the permissive trip.
// RULE9 - In three-frequency mode a low shift gives the direct transfer trip.
// RULE10 - In three-frequency mode the center frequency gives guard.
// RULE11 - In phase mode mark and space alternate about sixty times a second.
// RULE12 - Phase mode drives mark, space, low level and noise outputs only.
// RULE13 - Two-frequency mode drives five solid-state and two relay-stage outputs.
// RULE14 - Three-frequency mode drives five solid-state and two relay-stage outputs.
// RULE15 - Each timer offers a disabled setting beside its durations.
// RULE16 - The unblock timer opens a trip window on low level with no guard.
// RULE17 - All discriminator inputs are synchronised before any decision. The noise interrupt event also samples the first stage q.s1.noise.
//
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
module crt_trip_logic (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire crt_pkg::crt_disc_s disc_in,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [3:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic [31:0]           wb_dat_o,
  output logic                  wb_ack_o,
  output crt_pkg::crt_led_s     led_o,
  output crt_pkg::crt_out_s     out_o,
  output logic                  irq_o
);

  typedef struct packed {
    crt_pkg::crt_disc_s   s1;
    crt_pkg::crt_disc_s   s2;
    logic [12:0]          ctrl;
    logic [3:0]           irq_stat;
    logic [3:0]           irq_mask;
    logic                 lost;      // Channel lost, no guard since
    logic [22:0]          ub_cnt;
    logic [22:0]          td_cnt;
    logic [22:0]          th_cnt;
    logic [22:0]          gh_cnt;
    logic                 ack;
    logic [31:0]          rdat;
    crt_pkg::crt_led_s    led;
    crt_pkg::crt_out_s    out;
    logic                 irq;
  } crt_state_s;

  crt_state_s q, d;

  function automatic logic [22:0] hold_cyc(input logic [1:0] sel);
    unique case (sel)
      2'h0:    hold_cyc = 23'h0;
      2'h1:    hold_cyc = 23'(crt_pkg::HOLD10_CYC);
      2'h2:    hold_cyc = 23'(crt_pkg::HOLD50_CYC);
      default: hold_cyc = 23'(crt_pkg::HOLD100_CYC);
    endcase
  endfunction : hold_cyc

  logic        sel_cb_f;
  logic        shift_f;
  logic        raw_trip;
  logic        ub_win;
  logic        trip_dly;
  logic        trip_out;
  logic        guard_in;
  logic        guard_out;
  logic        loc;
  logic        wb_req;
  logic [3:0]  ev;
  logic [1:0]  var_f;
  logic [3:0]  td_set;

  always_comb begin
    d      = q;
    d.s1   = disc_in;   // RULE1
    d.s2   = q.s1;      // RULE17
    var_f  = q.ctrl[crt_pkg::CTRL_VAR_LSB +: 2];
    td_set = q.ctrl[crt_pkg::CTRL_TDLY_LSB +: 4];
    wb_req = wb_cyc_i && wb_stb_i && !q.ack;

    guard_in = (var_f == 2'(crt_pkg::CRT_VAR_3F_DIR)) ? q.s2.center_f : q.s2.high_f; // RULE4 RULE10
    loc      = q.s2.low_level && !guard_in; // RULE16
    if (guard_in) begin
      d.lost = 1'b0;
    end else if (loc) begin
      d.lost = 1'b1;
    end

    // Unblock window: counts from channel loss, zero setting disables
    if (!loc || !q.ctrl[crt_pkg::CTRL_UBEN]) begin
      d.ub_cnt = 23'h0; // RULE15
    end else if (q.ub_cnt != 23'(crt_pkg::UNBLOCK_CYC)) begin
      d.ub_cnt = q.ub_cnt + 23'h1; // RULE16
    end

    sel_cb_f = q.ctrl[crt_pkg::CTRL_CBSEL] ? q.s2.high_f : q.s2.low_f; // RULE6
    shift_f  = (var_f == 2'(crt_pkg::CRT_VAR_3F_DIR)) ? sel_cb_f : q.s2.low_f;
    // Window closes once the count tops out, so a lasting loss cannot trip
    ub_win   = loc && q.ub_cnt != 23'h0 &&
               q.ub_cnt != 23'(crt_pkg::UNBLOCK_CYC); // RULE16
    raw_trip = q.s2.low_f || ub_win;

    // Trip delay: zero setting passes trip immediately
    if (!raw_trip) begin
      d.td_cnt = 23'h0;
    end else if (q.td_cnt != 23'(td_set) * 23'(crt_pkg::TDLY_STEP_CYC)) begin
      d.td_cnt = q.td_cnt + 23'h1;
    end
    trip_dly = raw_trip && (q.td_cnt == 23'(td_set) * 23'(crt_pkg::TDLY_STEP_CYC)); // RULE15

    // Trip and guard hold stretch outputs; disabled setting gives no stretch
    if (trip_dly) begin
      d.th_cnt = hold_cyc(q.ctrl[crt_pkg::CTRL_THOLD_LSB +: 2]);
    end else if (q.th_cnt != 23'h0) begin
      d.th_cnt = q.th_cnt - 23'h1;
    end
    if (guard_in) begin
      d.gh_cnt = hold_cyc(q.ctrl[crt_pkg::CTRL_GHOLD_LSB +: 2]);
    end else if (q.gh_cnt != 23'h0) begin
      d.gh_cnt = q.gh_cnt - 23'h1;
    end
    // Loss suppresses trip except inside the unblock window
    trip_out  = (trip_dly || q.th_cnt != 23'h0) && (!q.lost || ub_win); // RULE5 RULE7 RULE16
    guard_out = guard_in || q.gh_cnt != 23'h0;

    d.led = '0;
    d.out = '0;
    d.led.good_chan = !q.s2.noise && !q.s2.low_level; // RULE2
    unique case (var_f)
      2'(crt_pkg::CRT_VAR_3F_DIR): begin
        d.led.ubpt_trip    = q.s2.high_f && !(q.lost && q.ctrl[crt_pkg::CTRL_CBSEL]); // RULE8 RULE7
        d.led.dtt_trip     = trip_out; // RULE9
        d.led.guard        = guard_out; // RULE10
        d.led.checkback    = shift_f; // RULE6
        d.out.ss_trip2     = d.led.ubpt_trip; // RULE14
        d.out.ss_guard     = guard_out;
        d.out.ss_low       = q.s2.low_level;
        d.out.ss_checkback = shift_f;
        d.out.ss_noise     = q.s2.noise;
        d.out.em_trip      = trip_out || d.led.ubpt_trip;
        d.out.em_guard     = guard_out;
      end
      2'(crt_pkg::CRT_VAR_2F_PHASE): begin
        d.led.mark     = q.s2.high_f; // RULE11
        d.led.space    = q.s2.low_f; // RULE11
        d.out.ss_mark  = q.s2.high_f; // RULE12
        d.out.ss_space = q.s2.low_f;
        d.out.ss_low   = q.s2.low_level;
        d.out.ss_noise = q.s2.noise;
      end
      default: begin
        d.led.trip         = trip_out; // RULE3
        d.led.guard        = guard_out; // RULE4
        d.led.checkback    = shift_f; // RULE5
        d.out.ss_trip2     = trip_out; // RULE13
        d.out.ss_guard     = guard_out;
        d.out.ss_low       = q.s2.low_level;
        d.out.ss_checkback = shift_f;
        d.out.ss_noise     = q.s2.noise;
        d.out.em_trip      = trip_out;
        d.out.em_guard     = guard_out;
      end
    endcase

    // Sticky events; set wins over a write-one clear
    ev[crt_pkg::IRQ_TRIP] = trip_out && !q.led.trip && !q.led.dtt_trip;
    ev[crt_pkg::IRQ_CB]   = shift_f && !q.led.checkback;
    ev[crt_pkg::IRQ_LOC]  = loc && !q.lost;
    ev[crt_pkg::IRQ_NOIS] = q.s2.noise && !q.s1.noise;

    d.ack  = wb_req;
    d.rdat = 32'h0;
    if (wb_req && wb_we_i && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        crt_pkg::REG_CTRL: begin
          d.ctrl[7:0] = wb_dat_i[7:0];
        end
        crt_pkg::REG_IRQ:  d.irq_stat = q.irq_stat & ~wb_dat_i[3:0];
        crt_pkg::REG_MASK: d.irq_mask = wb_dat_i[3:0];
        default: ;
      endcase
    end
    if (wb_req && wb_we_i && wb_sel_i[1] && wb_adr_i == crt_pkg::REG_CTRL) begin
      d.ctrl[12:8] = wb_dat_i[12:8];
    end
    if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        crt_pkg::REG_CTRL:   d.rdat = {19'h0, q.ctrl};
        crt_pkg::REG_STATUS: d.rdat = {18'h0, q.lost, loc, 4'h0, q.led};
        crt_pkg::REG_IRQ:    d.rdat = {28'h0, q.irq_stat};
        crt_pkg::REG_MASK:   d.rdat = {28'h0, q.irq_mask};
        default:             d.rdat = 32'h0;
      endcase
    end
    d.irq_stat = d.irq_stat | ev;
    d.irq      = |(q.irq_stat & q.irq_mask);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q      <= '0;
      q.ctrl <= crt_pkg::CTRL_RESET;
    end else begin
      q <= d;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdat;
  assign led_o    = q.led;
  assign out_o    = q.out;
  assign irq_o    = q.irq;

endmodule : crt_trip_logic

// file: verification/crt_disc_model.sv
// Discriminator stand-in: one tone code plus noise and low level flags.
// Assumes the bench changes its command just after a rising edge.
`timescale 1ns/10ps
module crt_disc_model (
  input  wire logic         tone_en,
  input  wire logic [1:0]   tone,
  input  wire logic         noise,
  input  wire logic         low_lvl,
  output crt_pkg::crt_disc_s disc
);
  // Only one tone flag at a time, as a real discriminator reports
  always_comb begin
    disc.high_f    = tone_en && (tone == 2'h1);
    disc.center_f  = tone_en && (tone == 2'h2);
    disc.low_f     = tone_en && (tone == 2'h3);
    disc.noise     = noise;
    disc.low_level = low_lvl;
  end
endmodule : crt_disc_model

// file: verification/crt_trip_logic_properties.sv
// Port checker for the receiver trip logic.
// Assumes all hold and delay timers stay disabled.
`timescale 1ns/10ps
module crt_trip_logic_props (
  input wire logic               sys_clk,
  input wire logic               rst_b,
  input wire crt_pkg::crt_disc_s disc_in,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_ack_o,
  input wire crt_pkg::crt_led_s  led_o,
  input wire crt_pkg::crt_out_s  out_o
);
  logic [2:0] up_q;
  // Past values are stale for a few edges after reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  good_chan_a: assert property (up_q == 3'h7 |-> led_o.good_chan ==
    !($past(disc_in.noise, 3) || $past(disc_in.low_level, 3))) else $error("good channel");
  trip_cause_a: assert property (led_o.trip |->
    $past(disc_in.low_f, 3) || $past(disc_in.low_level, 3)) else $error("trip without cause");
  guard_cause_a: assert property (led_o.guard |->
    $past(disc_in.high_f, 3) || $past(disc_in.center_f, 3)) else $error("guard cause");
  cb_cause_a: assert property (led_o.checkback |->
    $past(disc_in.low_f, 3) || $past(disc_in.high_f, 3)) else $error("checkback cause");
  noise_out_a: assert property (up_q == 3'h7 |->
    out_o.ss_noise == $past(disc_in.noise, 3)) else $error("noise output");
  tone_excl_a: assert property (!(led_o.mark && led_o.space) &&
    !(led_o.ubpt_trip && led_o.dtt_trip)) else $error("exclusive indicators");
endmodule : crt_trip_logic_props
bind crt_trip_logic crt_trip_logic_props u_props (.sys_clk(sys_clk), .rst_b(rst_b),
  .disc_in(disc_in), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .led_o(led_o), .out_o(out_o));

// file: verification/crt_trip_logic_tb.sv
// Bench for the receiver trip logic: Wishbone tasks and tone sequences.
// Assumes a 40 MHz clock and every hold and delay timer left disabled; test 2 enables the unblock window.
`timescale 1ns/10ps
module crt_trip_logic_tb;
  logic sys_clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, irq, ack;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] dat_w = 32'h0, dat_r, rdat;
  logic [1:0] tone = 2'h0;
  logic noise = 1'b0, low_lvl = 1'b0;
  crt_pkg::crt_disc_s disc;
  crt_pkg::crt_led_s led;
  crt_pkg::crt_out_s outs;
  int err_total = 0, compares = 0, cyc_cnt = 0;
  always #12.5 sys_clk = ~sys_clk;
  crt_disc_model u_disc (.tone_en(1'b1), .tone(tone), .noise(noise), .low_lvl(low_lvl),
    .disc(disc));
  crt_trip_logic dut (.sys_clk(sys_clk), .rst_b(rst_b), .disc_in(disc), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .led_o(led), .out_o(outs), .irq_o(irq));
  task automatic end_sim();
    $display("compares=%0d mismatches=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Request held until the edge that samples ack, then released
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat_w <= d;
    do @(posedge sys_clk); while (ack !== 1'b1);
    rdat = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask : rd
  task automatic step(input logic [1:0] t, input logic n, input logic l, input logic [7:0] e);
    tone <= t;
    noise <= n;
    low_lvl <= l;
    repeat (6) @(posedge sys_clk);
    chk({24'h0, led}, {24'h0, e});
  endtask : step
  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(4'h0, 32'h0);
    rd(4'h8, 32'h0);
    rd(4'hc, 32'h0);
    bus(1'b1, 4'h2, 32'hffff_ffff);
    rd(4'h2, 32'h0);
    bus(1'b1, 4'h4, 32'hffff_ffff);
    rd(4'h4, 32'h80);
    $display("test 1 done");
    bus(1'b1, 4'hc, 32'h1);
    step(2'h3, 1'b0, 1'b0, 8'hd0);
    chk({23'h0, outs}, 32'h122);
    chk({31'h0, irq}, 32'h1);
    step(2'h1, 1'b0, 1'b0, 8'ha0);
    rd(4'h8, 32'h3);
    bus(1'b1, 4'hc, 32'h0);
    step(2'h1, 1'b0, 1'b0, 8'ha0);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, 4'h8, 32'h1);
    rd(4'h8, 32'h2);
    step(2'h0, 1'b0, 1'b1, 8'h00);
    step(2'h3, 1'b0, 1'b1, 8'h10);
    step(2'h1, 1'b1, 1'b0, 8'h20);
    bus(1'b1, 4'h0, 32'h1000);
    step(2'h0, 1'b0, 1'b1, 8'h40);
    $display("test 2 done");
    bus(1'b1, 4'h0, 32'h5);
    step(2'h2, 1'b0, 1'b0, 8'ha0);
    chk({23'h0, outs}, 32'h081);
    step(2'h1, 1'b0, 1'b0, 8'h98);
    step(2'h3, 1'b0, 1'b0, 8'h84);
    bus(1'b1, 4'h0, 32'h1);
    step(2'h3, 1'b0, 1'b0, 8'h94);
    step(2'h0, 1'b0, 1'b1, 8'h00);
    step(2'h3, 1'b0, 1'b1, 8'h10);
    $display("test 3 done");
    bus(1'b1, 4'h0, 32'h2);
    step(2'h1, 1'b0, 1'b0, 8'h82);
    step(2'h3, 1'b0, 1'b0, 8'h81);
    step(2'h3, 1'b1, 1'b0, 8'h01);
    chk({23'h0, outs}, 32'h014);
    $display("test 4 done");
    end_sim();
  end
endmodule : crt_trip_logic_tb
